// ---- rtl/pecr_hdr_log.sv ----
// Purpose: Header log capture of first uncorrectable error
// Assumes: Capture strobe is a one-cycle pulse on clk_sys
// Notes: Software writes allowed; capture wins over write
`timescale 1ns/100ps
module pecr_hdr_log (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Error side
    input wire logic err_capture,
    input wire logic [127:0] err_header,
    input wire logic [4:0] err_status_bit,
    input wire logic [31:0] uncorrectable_error_status,
    // Software side
    input wire logic [1:0] sw_index,
    input wire logic sw_write,
    input wire logic [31:0] sw_data,
    input wire logic ptr_write,
    input wire logic [4:0] ptr_data,
    // Results
    output logic [127:0] header_log_word,
    output logic [4:0] first_error_pointer,
    output logic log_held
);
    typedef struct packed {
        logic [127:0] words;
        logic [4:0] ptr;
        logic held;
    } pecr_log_state_type;

    pecr_log_state_type state_reg;
    pecr_log_state_type state_next;
    logic ptr_live;

    // Entry stays locked while its status bit is still set
    assign ptr_live = uncorrectable_error_status[state_reg.ptr];

    always_comb begin
        state_next = state_reg;
        if (state_reg.held && !ptr_live) begin
            state_next.held = 1'b0;
        end
        if (sw_write) begin
            state_next.words[sw_index*32 +: 32] = sw_data;
        end
        if (ptr_write) begin
            state_next.ptr = ptr_data;
        end
        if (err_capture && !(state_reg.held && ptr_live)) begin
            state_next.words = err_header;
            state_next.ptr = err_status_bit;
            state_next.held = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign header_log_word = state_reg.words;
    assign first_error_pointer = state_reg.ptr;
    assign log_held = state_reg.held;

    chk_log_first_capture: assert property (@(posedge clk_sys) disable iff (rst)
        (err_capture && !(log_held && ptr_live)) |=> header_log_word == $past(err_header))
        else $error("header not captured");
    chk_log_held_keeps: assert property (@(posedge clk_sys) disable iff (rst)
        (err_capture && log_held && ptr_live && !sw_write) |=>
        header_log_word == $past(header_log_word))
        else $error("second error overwrote log");
    chk_ptr_follows: assert property (@(posedge clk_sys) disable iff (rst)
        (err_capture && !(log_held && ptr_live)) |=> first_error_pointer == $past(err_status_bit))
        else $error("pointer not updated");
    cov_capture: cover property (@(posedge clk_sys) err_capture && !log_held);
    cov_blocked: cover property (@(posedge clk_sys) err_capture && log_held && ptr_live);
endmodule : pecr_hdr_log

// ---- rtl/pecr_pkg.sv ----
// Purpose: Constants for the extended capability register bank
// Assumes: Plain register port, 32-bit words at byte offsets
// Notes: Functional notes listed below
//
// Functional notes
// - Log four header words of first error
// - Five-bit pointer names logged status bit
// - Serial header identifier reads 0x3
// - Both headers report version 0x1
// - Twelve-bit next pointer, zero ends chain
// - 64-bit identifier over two words, reset zero
// - Channel header identifier reads 0x2
// - Extra channel count defaults zero
// - Low-priority channel count defaults zero
// - Arbitration time base reads zero
// - Port table entry size defaults 4-bit
// - Channel arbitration fields read zero
// - Port channel control bits writable, inert
package pecr_pkg;
    // ==========================================================
    // Offsets
    localparam logic [11:0] OFS_HLOG_DW1 = 12'h11c;
    localparam logic [11:0] OFS_HLOG_DW2 = 12'h120;
    localparam logic [11:0] OFS_HLOG_DW3 = 12'h124;
    localparam logic [11:0] OFS_HLOG_DW4 = 12'h128;
    localparam logic [11:0] OFS_ERR_CTL = 12'h118;
    localparam logic [11:0] OFS_SER_HDR = 12'h180;
    localparam logic [11:0] OFS_SER_LOW = 12'h184;
    localparam logic [11:0] OFS_SER_HIGH = 12'h188;
    localparam logic [11:0] OFS_VC_HDR = 12'h200;
    localparam logic [11:0] OFS_VC_CAP_A = 12'h204;
    localparam logic [11:0] OFS_VC_CAP_B = 12'h208;
    localparam logic [11:0] OFS_VC_CTL = 12'h20c;
    // ==========================================================
    // Field positions
    localparam int CAP_ID_LSB = 0;
    localparam int CAP_VER_LSB = 16;
    localparam int NEXT_PTR_LSB = 20;
    localparam int EXTRA_CNT_LSB = 0;
    localparam int LOWPRI_CNT_LSB = 4;
    localparam int TIME_BASE_LSB = 8;
    localparam int ENTRY_SIZE_LSB = 10;
    localparam int CHAN_ARB_CAP_LSB = 0;
    localparam int CHAN_TBL_OFS_LSB = 24;
    localparam int LOAD_TBL_BIT = 0;
    localparam int ARB_SEL_LSB = 1;
    // ==========================================================
    // Fixed and reset values
    localparam logic [15:0] SER_CAP_ID = 16'h0003;
    localparam logic [15:0] VC_CAP_ID = 16'h0002;
    localparam logic [3:0] CAP_VERSION = 4'h1;
    localparam logic [11:0] NEXT_PTR_RST = 12'h000;
    localparam logic [2:0] EXTRA_CNT_RST = 3'h0;
    localparam logic [2:0] LOWPRI_CNT_RST = 3'h0;
    localparam logic [1:0] TIME_BASE_VAL = 2'h0;
    localparam logic [1:0] ENTRY_SIZE_RST = 2'h2;
    localparam logic [7:0] CHAN_ARB_CAP_VAL = 8'h00;
    localparam logic [7:0] CHAN_TBL_OFS_VAL = 8'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam int HDR_WORDS = 4;
endpackage : pecr_pkg

// ---- rtl/pecr_regs.sv ----
// Purpose: Extended capability register bank of one switch port
// Assumes: Single clock, plain register port, no stalls
// Notes: Read data valid one cycle after the read strobe
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
module pecr_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Error capture from the port logic
    input wire logic err_capture,
    input wire logic [127:0] err_header,
    input wire logic [4:0] err_status_bit,
    input wire logic [31:0] uncorrectable_error_status,
    // Settings seen by the port
    output logic [63:0] serial_number,
    output logic load_channel_table,
    output logic [2:0] channel_arbitration_select
);
    // Map offsets need the full 12 address bits
    if (ADDR_W < 12) begin : g_addr_w_check
        $error("ADDR_W too small for register map");
    end

    typedef struct packed {
        logic [31:0] rdata;
        logic [31:0] ser_low;
        logic [31:0] ser_high;
        logic [11:0] ser_next;
        logic [11:0] vc_next;
        logic [2:0] extra_cnt;
        logic [2:0] lowpri_cnt;
        logic [1:0] entry_size;
        logic load_tbl;
        logic [2:0] arb_sel;
    } pecr_state_type;

    pecr_state_type state_reg;
    pecr_state_type state_next;
    logic [127:0] hdr_words;
    logic [4:0] first_ptr;
    logic hdr_sw_write;
    logic [1:0] hdr_index;
    logic ptr_write;

    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction : hit

    function automatic logic [31:0] cap_header(input logic [15:0] id, input logic [11:0] nxt);
        cap_header = '0;
        cap_header[pecr_pkg::CAP_VER_LSB +: 4] = pecr_pkg::CAP_VERSION;
        cap_header[pecr_pkg::CAP_ID_LSB +: 16] = id;
        cap_header[pecr_pkg::NEXT_PTR_LSB +: 12] = nxt;
    endfunction : cap_header

    logic hit_hlog;
    assign hit_hlog = hit(reg_addr, pecr_pkg::OFS_HLOG_DW1) || hit(reg_addr, pecr_pkg::OFS_HLOG_DW2)
        || hit(reg_addr, pecr_pkg::OFS_HLOG_DW3) || hit(reg_addr, pecr_pkg::OFS_HLOG_DW4);
    assign hdr_sw_write = reg_write && hit_hlog;
    // Index only meaningful on a log hit
    assign hdr_index = 2'((reg_addr[11:0] - pecr_pkg::OFS_HLOG_DW1) >> 2);
    assign ptr_write = reg_write && hit(reg_addr, pecr_pkg::OFS_ERR_CTL);

    // ==========================================================
    // Header log
    pecr_hdr_log i_pecr_hdr_log (
        .clk_sys(clk_sys),
        .rst(rst),
        .err_capture(err_capture),
        .err_header(err_header),
        .err_status_bit(err_status_bit),
        .uncorrectable_error_status(uncorrectable_error_status),
        .sw_index(hdr_index),
        .sw_write(hdr_sw_write),
        .sw_data(reg_wdata),
        .ptr_write(ptr_write),
        .ptr_data(reg_wdata[4:0]),
        .header_log_word(hdr_words),
        .first_error_pointer(first_ptr),
        .log_held()
    );

    // ==========================================================
    // Register update and read mux
    always_comb begin
        state_next = state_reg;
        // Read data idles at zero so stale words never linger
        state_next.rdata = '0;
        if (reg_write) begin
            if (hit(reg_addr, pecr_pkg::OFS_SER_LOW)) begin
                state_next.ser_low = reg_wdata;
            end
            if (hit(reg_addr, pecr_pkg::OFS_SER_HIGH)) begin
                state_next.ser_high = reg_wdata;
            end
            if (hit(reg_addr, pecr_pkg::OFS_SER_HDR)) begin
                state_next.ser_next = reg_wdata[pecr_pkg::NEXT_PTR_LSB +: 12];
            end
            if (hit(reg_addr, pecr_pkg::OFS_VC_HDR)) begin
                state_next.vc_next = reg_wdata[pecr_pkg::NEXT_PTR_LSB +: 12];
            end
            if (hit(reg_addr, pecr_pkg::OFS_VC_CAP_A)) begin
                state_next.extra_cnt = reg_wdata[pecr_pkg::EXTRA_CNT_LSB +: 3];
                state_next.lowpri_cnt = reg_wdata[pecr_pkg::LOWPRI_CNT_LSB +: 3];
                state_next.entry_size = reg_wdata[pecr_pkg::ENTRY_SIZE_LSB +: 2];
            end
            if (hit(reg_addr, pecr_pkg::OFS_VC_CTL)) begin
                state_next.load_tbl = reg_wdata[pecr_pkg::LOAD_TBL_BIT];
                state_next.arb_sel = reg_wdata[pecr_pkg::ARB_SEL_LSB +: 3];
            end
        end
        if (reg_read) begin
            unique case (1'b1)
                hit_hlog: begin
                    state_next.rdata = hdr_words[hdr_index*32 +: 32];
                end
                hit(reg_addr, pecr_pkg::OFS_ERR_CTL): begin
                    state_next.rdata = {27'h0, first_ptr};
                end
                hit(reg_addr, pecr_pkg::OFS_SER_HDR): begin
                    state_next.rdata = cap_header(pecr_pkg::SER_CAP_ID, state_reg.ser_next);
                end
                hit(reg_addr, pecr_pkg::OFS_SER_LOW): begin
                    state_next.rdata = state_reg.ser_low;
                end
                hit(reg_addr, pecr_pkg::OFS_SER_HIGH): begin
                    state_next.rdata = state_reg.ser_high;
                end
                hit(reg_addr, pecr_pkg::OFS_VC_HDR): begin
                    state_next.rdata = cap_header(pecr_pkg::VC_CAP_ID, state_reg.vc_next);
                end
                hit(reg_addr, pecr_pkg::OFS_VC_CAP_A): begin
                    state_next.rdata[pecr_pkg::EXTRA_CNT_LSB +: 3] = state_reg.extra_cnt;
                    state_next.rdata[pecr_pkg::LOWPRI_CNT_LSB +: 3] = state_reg.lowpri_cnt;
                    state_next.rdata[pecr_pkg::TIME_BASE_LSB +: 2] = pecr_pkg::TIME_BASE_VAL;
                    state_next.rdata[pecr_pkg::ENTRY_SIZE_LSB +: 2] = state_reg.entry_size;
                end
                hit(reg_addr, pecr_pkg::OFS_VC_CAP_B): begin
                    state_next.rdata[pecr_pkg::CHAN_ARB_CAP_LSB +: 8] = pecr_pkg::CHAN_ARB_CAP_VAL;
                    state_next.rdata[pecr_pkg::CHAN_TBL_OFS_LSB +: 8] = pecr_pkg::CHAN_TBL_OFS_VAL;
                end
                hit(reg_addr, pecr_pkg::OFS_VC_CTL): begin
                    state_next.rdata[pecr_pkg::LOAD_TBL_BIT] = state_reg.load_tbl;
                    state_next.rdata[pecr_pkg::ARB_SEL_LSB +: 3] = state_reg.arb_sel;
                end
                default: begin
                    state_next.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg.rdata <= pecr_pkg::WORD_RST;
            state_reg.ser_low <= pecr_pkg::WORD_RST;
            state_reg.ser_high <= pecr_pkg::WORD_RST;
            state_reg.ser_next <= pecr_pkg::NEXT_PTR_RST;
            state_reg.vc_next <= pecr_pkg::NEXT_PTR_RST;
            state_reg.extra_cnt <= pecr_pkg::EXTRA_CNT_RST;
            state_reg.lowpri_cnt <= pecr_pkg::LOWPRI_CNT_RST;
            // Entry size is the only non-zero default
            state_reg.entry_size <= pecr_pkg::ENTRY_SIZE_RST;
            state_reg.load_tbl <= 1'b0;
            state_reg.arb_sel <= 3'h0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign serial_number = {state_reg.ser_high, state_reg.ser_low};
    assign load_channel_table = state_reg.load_tbl;
    assign channel_arbitration_select = state_reg.arb_sel;

    // ==========================================================
    // Checks
    chk_ser_hdr_id: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && hit(reg_addr, pecr_pkg::OFS_SER_HDR)) |=> reg_rdata[19:0] == 20'h10003)
        else $error("serial header id/version wrong");
    chk_vc_hdr_id: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && hit(reg_addr, pecr_pkg::OFS_VC_HDR)) |=> reg_rdata[19:0] == 20'h10002)
        else $error("channel header id/version wrong");
    chk_hdr_version: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && (hit(reg_addr, pecr_pkg::OFS_SER_HDR) || hit(reg_addr, pecr_pkg::OFS_VC_HDR)))
        |=> reg_rdata[19:16] == 4'h1)
        else $error("version not 1");
    chk_next_ptr: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_write && hit(reg_addr, pecr_pkg::OFS_VC_HDR)) ##1
        (reg_read && hit(reg_addr, pecr_pkg::OFS_VC_HDR)) |=> reg_rdata[31:20] == $past(reg_wdata[31:20], 2))
        else $error("next pointer not kept");
    chk_serial_write: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_write && hit(reg_addr, pecr_pkg::OFS_SER_HIGH)) |=> serial_number[63:32] == $past(reg_wdata))
        else $error("upper serial half not stored");
    chk_cap_b_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && hit(reg_addr, pecr_pkg::OFS_VC_CAP_B)) |=> reg_rdata == 32'h0000_0000)
        else $error("cap b not zero");
    chk_cap_a_rsvd: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && hit(reg_addr, pecr_pkg::OFS_VC_CAP_A)) |=> reg_rdata[9:8] == 2'h0 && reg_rdata[31:12] == 20'h0)
        else $error("cap a fixed bits wrong");
    chk_entry_reset: assert property (@(posedge clk_sys)
        $fell(rst) |-> state_reg.entry_size == 2'h2 && state_reg.extra_cnt == 3'h0 && state_reg.lowpri_cnt == 3'h0)
        else $error("cap a reset wrong");
    chk_ctl_rsvd: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && hit(reg_addr, pecr_pkg::OFS_VC_CTL)) |=> reg_rdata[31:4] == 28'h0)
        else $error("control reserved bits set");
    chk_ctl_store: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_write && hit(reg_addr, pecr_pkg::OFS_VC_CTL)) |=> channel_arbitration_select == $past(reg_wdata[3:1]))
        else $error("arbitration select not stored");
    chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst)
        !reg_read |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");

    // ==========================================================
    // Checks: reset values
    chk_rdata_reset: assert property (@(posedge clk_sys)
        rst
        |=> reg_rdata == 32'h0000_0000)
        else $error("read data not cleared by reset");
    chk_serial_reset: assert property (@(posedge clk_sys)
        $fell(rst)
        |-> serial_number == 64'h0)
        else $error("serial number not cleared by reset");
    chk_ctl_reset: assert property (@(posedge clk_sys)
        $fell(rst)
        |-> !load_channel_table && channel_arbitration_select == 3'h0)
        else $error("control bits not cleared by reset");
    chk_next_reset: assert property (@(posedge clk_sys)
        $fell(rst)
        |-> state_reg.ser_next == 12'h000 && state_reg.vc_next == 12'h000)
        else $error("next pointers not cleared by reset");

    // ==========================================================
    // Checks: serial number
    chk_serial_low: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_write && hit(reg_addr, pecr_pkg::OFS_SER_LOW))
        |=> serial_number[31:0] == $past(reg_wdata))
        else $error("lower serial half not stored");
    chk_serial_read: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && hit(reg_addr, pecr_pkg::OFS_SER_HIGH))
        |=> reg_rdata == serial_number[63:32])
        else $error("upper serial half read wrong");

    // ==========================================================
    // Checks: channel registers
    chk_cap_a_gaps: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && hit(reg_addr, pecr_pkg::OFS_VC_CAP_A))
        |=> reg_rdata[3] == 1'b0 && reg_rdata[7] == 1'b0)
        else $error("cap a reserved bits set");
    chk_entry_store: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_write && hit(reg_addr, pecr_pkg::OFS_VC_CAP_A))
        |=> state_reg.entry_size == $past(reg_wdata[11:10]))
        else $error("entry size not stored");
    chk_load_store: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_write && hit(reg_addr, pecr_pkg::OFS_VC_CTL))
        |=> load_channel_table == $past(reg_wdata[0]))
        else $error("load bit not stored");
    chk_ctl_read: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && hit(reg_addr, pecr_pkg::OFS_VC_CTL))
        |=> reg_rdata[3:0] == {channel_arbitration_select, load_channel_table})
        else $error("control read wrong");

    // ==========================================================
    // Checks: error log
    chk_err_ctl_rsvd: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && hit(reg_addr, pecr_pkg::OFS_ERR_CTL))
        |=> reg_rdata[31:5] == 27'h0)
        else $error("pointer word reserved bits set");
    chk_log_dw4: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_read && hit(reg_addr, pecr_pkg::OFS_HLOG_DW4))
        |=> reg_rdata == $past(hdr_words[127:96]))
        else $error("fourth log word read wrong");

    // ==========================================================
    // Coverage
    cov_ser_read: cover property (@(posedge clk_sys) reg_read && hit(reg_addr, pecr_pkg::OFS_SER_LOW));
    cov_ctl_write: cover property (@(posedge clk_sys) reg_write && hit(reg_addr, pecr_pkg::OFS_VC_CTL));
    cov_back2back: cover property (@(posedge clk_sys) reg_write ##1 reg_read);
endmodule : pecr_regs

// ---- test/test_pecr_regs.sv ----
// Purpose: Self-checking bench for the extended capability register bank
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: A monitor drains the queue of expected read words
`timescale 1ns/100ps
module test_pecr_regs;
    // ==========================================================
    // Ports and bookkeeping
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic err_capture = 1'b0;
    logic [127:0] err_header = 128'h0;
    logic [4:0] err_status_bit = 5'h00;
    logic [31:0] uncorrectable_error_status = 32'h0;
    logic [63:0] serial_number;
    logic load_channel_table;
    logic [2:0] channel_arbitration_select;
    int fails = 0;
    int tests_run = 0;
    logic [31:0] exp_q[$];
    logic [15:0] lfsr = 16'h49e8;
    logic rd_pend = 1'b0;

    always #4 clk_sys = ~clk_sys;

    pecr_regs #(.ADDR_W(12)) i_pecr_regs (
        .clk_sys(clk_sys),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .err_capture(err_capture),
        .err_header(err_header),
        .err_status_bit(err_status_bit),
        .uncorrectable_error_status(uncorrectable_error_status),
        .serial_number(serial_number),
        .load_channel_table(load_channel_table),
        .channel_arbitration_select(channel_arbitration_select)
    );

    // ==========================================================
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic rnd32(output logic [31:0] v);
        lfsr = lfsr_next(lfsr);
        v[15:0] = lfsr;
        lfsr = lfsr_next(lfsr);
        v[31:16] = lfsr;
    endtask : rnd32

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic stop_test();
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // Both strobes set in every bus task, so requests may run back to back
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        reg_read <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        reg_write <= 1'b0;
        exp_q.push_back(e);
    endtask : rd

    task automatic idle();
        @(posedge clk_sys);
        reg_read <= 1'b0;
        reg_write <= 1'b0;
        err_capture <= 1'b0;
    endtask : idle

    task automatic cap(input logic [4:0] pb, output logic [127:0] h);
        logic [31:0] w;
        for (int i = 0; i < 4; i++) begin
            rnd32(w);
            h[32*i +: 32] = w;
        end
        @(posedge clk_sys);
        reg_read <= 1'b0;
        reg_write <= 1'b0;
        err_header <= h;
        err_status_bit <= pb;
        err_capture <= 1'b1;
        idle();
    endtask : cap

    task automatic rd_log(input logic [127:0] h);
        for (int i = 0; i < 4; i++) begin
            rd(pecr_pkg::OFS_HLOG_DW1 + 12'(4 * i), h[32*i +: 32]);
        end
    endtask : rd_log

    // ==========================================================
    // Read monitor: rdata is valid only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rd_pend) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("[ERR] read_queue expected note seen none");
            end else begin
                check("reg_rdata", exp_q.pop_front(), reg_rdata);
            end
        end
        rd_pend <= reg_read & ~rst;
    end

    // ==========================================================
    // Main sequence
    initial begin : main_seq
        logic [127:0] h1;
        logic [127:0] h2;
        logic [31:0] w0;
        logic [31:0] w1;
        logic [4:0] pb;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(pecr_pkg::OFS_SER_HDR, 32'h0001_0003);
        rd(pecr_pkg::OFS_VC_HDR, 32'h0001_0002);
        rd(pecr_pkg::OFS_VC_CAP_A, 32'h0000_0800);
        rd(pecr_pkg::OFS_VC_CAP_B, 32'h0000_0000);
        rd(pecr_pkg::OFS_VC_CTL, 32'h0000_0000);
        rd(pecr_pkg::OFS_SER_LOW, 32'h0000_0000);
        rd(pecr_pkg::OFS_SER_HIGH, 32'h0000_0000);
        rd_log(128'h0);
        // All ones to both headers, the channel registers and unmapped 0x300: only writable fields may stick
        wr(pecr_pkg::OFS_SER_HDR, 32'hffff_ffff);
        wr(pecr_pkg::OFS_VC_HDR, 32'hffff_ffff);
        wr(pecr_pkg::OFS_VC_CAP_A, 32'hffff_ffff);
        wr(pecr_pkg::OFS_VC_CAP_B, 32'hffff_ffff);
        wr(pecr_pkg::OFS_VC_CTL, 32'hffff_ffff);
        wr(12'h300, 32'hffff_ffff);
        rd(pecr_pkg::OFS_SER_HDR, 32'hfff1_0003);
        rd(pecr_pkg::OFS_VC_HDR, 32'hfff1_0002);
        rd(pecr_pkg::OFS_VC_CAP_A, 32'h0000_0c77);
        rd(pecr_pkg::OFS_VC_CAP_B, 32'h0000_0000);
        rd(pecr_pkg::OFS_VC_CTL, 32'h0000_000f);
        rd(12'h300, 32'h0000_0000);
        idle();
        @(negedge clk_sys);
        check("load_channel_table", 32'h1, {31'h0, load_channel_table});
        check("arb_select", 32'h7, {29'h0, channel_arbitration_select});
        wr(pecr_pkg::OFS_SER_HDR, 32'h0000_0000);
        rd(pecr_pkg::OFS_SER_HDR, 32'h0001_0003);
        wr(pecr_pkg::OFS_VC_HDR, 32'h2a5f_ffff);
        rd(pecr_pkg::OFS_VC_HDR, 32'h2a51_0002);
        for (int i = 0; i < 4; i++) begin
            wr(pecr_pkg::OFS_VC_CAP_A, {20'h0, 2'(i), 10'h0});
            rd(pecr_pkg::OFS_VC_CAP_A, {20'h0, 2'(i), 10'h0});
        end
        // Serial number halves and the port view
        rnd32(w0);
        rnd32(w1);
        wr(pecr_pkg::OFS_SER_LOW, w0);
        wr(pecr_pkg::OFS_SER_HIGH, w1);
        rd(pecr_pkg::OFS_SER_LOW, w0);
        rd(pecr_pkg::OFS_SER_HIGH, w1);
        idle();
        @(negedge clk_sys);
        check("serial_low", w0, serial_number[31:0]);
        check("serial_high", w1, serial_number[63:32]);
        // First error held while its status bit stays set
        pb = lfsr[4:0];
        idle();
        uncorrectable_error_status <= 32'h1 << pb;
        cap(pb, h1);
        rd_log(h1);
        rd(pecr_pkg::OFS_ERR_CTL, {27'h0, pb});
        cap(pb ^ 5'h01, h2);
        rd_log(h1);
        rd(pecr_pkg::OFS_ERR_CTL, {27'h0, pb});
        idle();
        uncorrectable_error_status <= 32'h0;
        cap(pb ^ 5'h01, h2);
        rd_log(h2);
        rd(pecr_pkg::OFS_ERR_CTL, {27'h0, pb ^ 5'h01});
        // Pointer and log words also take software writes
        wr(pecr_pkg::OFS_ERR_CTL, 32'hffff_ffe5);
        rd(pecr_pkg::OFS_ERR_CTL, 32'h0000_0005);
        wr(pecr_pkg::OFS_HLOG_DW3, w0);
        rd(pecr_pkg::OFS_HLOG_DW3, w0);
        // Second reset in mid-run clears the state again
        idle();
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(pecr_pkg::OFS_SER_LOW, 32'h0000_0000);
        rd(pecr_pkg::OFS_HLOG_DW1, 32'h0000_0000);
        idle();
        for (int n = 0; n < 10 && exp_q.size() != 0; n++) begin
            @(posedge clk_sys);
        end
        if (exp_q.size() != 0) begin
            fails++;
            $display("[ERR] read_queue expected empty seen %0d left", exp_q.size());
        end
        stop_test();
    end : main_seq
endmodule : test_pecr_regs
